// ===== verilog/timer16_counter_capture.sv
// 16-bit timer counter with input capture and shared high-byte temporary
`timescale 1ns/1ps
module timer16_counter_capture #(
  parameter bit FIRST_INSTANCE = 1'b1
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic srst_i,
  // cpu i/o port
  input wire logic [2:0] cpu_addr_i,
  input wire logic cpu_rd_i,
  input wire logic cpu_wr_i,
  input wire logic [7:0] cpu_wdata_i,
  output logic [7:0] cpu_rdata_o,
  // control fields
  input wire logic [2:0] clock_select_field_i,
  input wire logic [3:0] waveform_mode_field_i,
  input wire logic capture_rising_i,
  input wire logic use_comparator_i,
  input wire logic capture_irq_enable_i,
  input wire logic overflow_irq_enable_i,
  // interrupt service acknowledges
  input wire logic capture_irq_ack_i,
  input wire logic overflow_irq_ack_i,
  // tick sources and trigger inputs
  input wire logic [3:0] prescale_tick_i,
  input wire logic ext_clock_pin_i,
  input wire logic capture_input_pin_i,
  input wire logic comparator_output_i,
  // status outputs
  output logic [15:0] count_value_o,
  output logic at_bottom_o,
  output logic at_top_o,
  output logic overflow_irq_o,
  output logic capture_irq_o
);
  // ==========================================================
  // state
  logic [15:0] count_value;
  logic [15:0] capture_register;
  logic [15:0] compare_a;
  logic [7:0] temp_high;
  logic overflow_flag;
  logic capture_flag;
  logic count_down;
  logic ext_prev;
  logic trig_prev;

  // ==========================================================
  // cpu decode
  wire logic rd_cnt_low = cpu_rd_i && (cpu_addr_i == timer16_pkg::LOC_CNT_LOW);
  wire logic rd_cap_low = cpu_rd_i && (cpu_addr_i == timer16_pkg::LOC_CAP_LOW);
  wire logic wr_cnt_low = cpu_wr_i && (cpu_addr_i == timer16_pkg::LOC_CNT_LOW);
  wire logic wr_cap_low = cpu_wr_i && (cpu_addr_i == timer16_pkg::LOC_CAP_LOW);
  wire logic wr_cmpa_low = cpu_wr_i && (cpu_addr_i == timer16_pkg::LOC_CMPA_LOW);
  wire logic wr_flags = cpu_wr_i && (cpu_addr_i == timer16_pkg::LOC_FLAGS);
  // every high location writes only the shared temporary
  wire logic wr_high = cpu_wr_i && ((cpu_addr_i == timer16_pkg::LOC_CNT_HIGH) ||
    (cpu_addr_i == timer16_pkg::LOC_CAP_HIGH) ||
    (cpu_addr_i == timer16_pkg::LOC_CMPA_HIGH));
  wire logic [15:0] cpu_word = {temp_high, cpu_wdata_i};

  // ==========================================================
  // mode decode
  wire logic [3:0] wgm = waveform_mode_field_i;
  wire logic icr_top_mode = (wgm == 4'h8) || (wgm == 4'ha) || (wgm == 4'hc) ||
    (wgm == 4'he);
  wire logic ocra_top_mode = (wgm == 4'h4) || (wgm == 4'h9) || (wgm == 4'hb) ||
    (wgm == 4'hf);
  wire logic dual_slope = ((wgm >= 4'h1) && (wgm <= 4'h3)) || ((wgm >= 4'h8) &&
    (wgm <= 4'hb));
  wire logic fast_mode = ((wgm >= 4'h5) && (wgm <= 4'h7)) || (wgm == 4'he) ||
    (wgm == 4'hf);
  wire logic ctc_mode = (wgm == 4'h4) || (wgm == 4'hc);
  logic [15:0] top_value;
  always_comb begin
    case (wgm[1:0])
      2'h1: top_value = timer16_pkg::TOP_8BIT;
      2'h2: top_value = timer16_pkg::TOP_9BIT;
      2'h3: top_value = timer16_pkg::TOP_10BIT;
      default: top_value = timer16_pkg::MAX_VALUE;
    endcase
    if (icr_top_mode) begin
      top_value = capture_register;
    end else if (ocra_top_mode) begin
      top_value = compare_a;
    end else if (wgm == 4'h0 || wgm == 4'hd) begin
      top_value = timer16_pkg::MAX_VALUE;
    end
  end

  // ==========================================================
  // tick selection
  wire logic ext_fall = ext_prev && !ext_clock_pin_i;
  wire logic ext_rise = !ext_prev && ext_clock_pin_i;
  logic timer_tick;
  always_comb begin
    case (clock_select_field_i)
      timer16_pkg::CS_STOP: timer_tick = 1'b0;
      timer16_pkg::CS_SYSCLK: timer_tick = 1'b1;
      timer16_pkg::CS_EXT_FALL: timer_tick = ext_fall;
      timer16_pkg::CS_EXT_RISE: timer_tick = ext_rise;
      default: timer_tick = prescale_tick_i[clock_select_field_i[1:0] - 2'h2];
    endcase
  end

  // ==========================================================
  // counter next value
  wire logic at_top = (count_value == top_value);
  wire logic at_bottom = (count_value == timer16_pkg::BOTTOM_VALUE);
  logic [15:0] next_count;
  logic next_down;
  logic ovf_event;
  always_comb begin
    next_count = count_value;
    next_down = count_down;
    ovf_event = 1'b0;
    if (timer_tick) begin
      if (dual_slope) begin
        if (at_top && !count_down) begin
          next_down = 1'b1;
        end else if (at_bottom && count_down) begin
          next_down = 1'b0;
          ovf_event = 1'b1;
        end
        if (next_down) begin
          next_count = count_value - 16'h0001;
        end else begin
          next_count = count_value + 16'h0001;
        end
      end else begin
        next_down = 1'b0;
        if (at_top && (fast_mode || ctc_mode)) begin
          next_count = timer16_pkg::BOTTOM_VALUE;
        end else begin
          next_count = count_value + 16'h0001;
        end
        ovf_event = fast_mode ? at_top : (count_value == timer16_pkg::MAX_VALUE);
      end
    end
    if (wr_cnt_low) begin
      next_count = cpu_word;
      ovf_event = 1'b0;
    end
  end

  // ==========================================================
  // capture trigger
  wire logic trig_src = (FIRST_INSTANCE && use_comparator_i) ? comparator_output_i :
    capture_input_pin_i;
  wire logic trig_edge = capture_rising_i ? (trig_src && !trig_prev) :
    (!trig_src && trig_prev);
  wire logic capture_evt = trig_edge && !icr_top_mode;
  wire logic next_cap_flag = capture_evt || (capture_flag && !capture_irq_ack_i &&
    !(wr_flags && cpu_wdata_i[timer16_pkg::FLAG_CAP_BIT]));
  wire logic next_ovf_flag = ovf_event || (overflow_flag && !overflow_irq_ack_i &&
    !(wr_flags && cpu_wdata_i[timer16_pkg::FLAG_OVF_BIT]));

  // ==========================================================
  // read mux
  logic [7:0] next_rdata;
  always_comb begin
    case (cpu_addr_i)
      timer16_pkg::LOC_CNT_LOW: next_rdata = count_value[7:0];
      timer16_pkg::LOC_CNT_HIGH: next_rdata = temp_high;
      timer16_pkg::LOC_CAP_LOW: next_rdata = capture_register[7:0];
      timer16_pkg::LOC_CAP_HIGH: next_rdata = temp_high;
      timer16_pkg::LOC_CMPA_LOW: next_rdata = compare_a[7:0];
      timer16_pkg::LOC_CMPA_HIGH: next_rdata = compare_a[15:8];
      timer16_pkg::LOC_FLAGS: begin
        next_rdata = 8'h00;
        next_rdata[timer16_pkg::FLAG_OVF_BIT] = overflow_flag;
        next_rdata[timer16_pkg::FLAG_CAP_BIT] = capture_flag;
      end
      default: next_rdata = 8'h00;
    endcase
  end

  // ==========================================================
  // registers
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      temp_high <= timer16_pkg::TEMP_RESET;
    end else if (wr_high) begin
      temp_high <= cpu_wdata_i;
    end else if (rd_cnt_low) begin
      temp_high <= count_value[15:8];
    end else if (rd_cap_low) begin
      temp_high <= capture_register[15:8];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      count_value <= timer16_pkg::COUNT_RESET;
      count_down <= 1'b0;
    end else begin
      count_value <= next_count;
      count_down <= next_down;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      capture_register <= timer16_pkg::CAPTURE_RESET;
    end else if (capture_evt) begin
      capture_register <= count_value;
    end else if (wr_cap_low && icr_top_mode) begin
      capture_register <= cpu_word;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      compare_a <= timer16_pkg::COMPARE_RESET;
    end else if (wr_cmpa_low) begin
      compare_a <= cpu_word;
    end
  end

  // flags: a new event wins over a clear in the same cycle
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      overflow_flag <= 1'b0;
      capture_flag <= 1'b0;
      ext_prev <= 1'b0;
      trig_prev <= 1'b0;
    end else begin
      overflow_flag <= next_ovf_flag;
      capture_flag <= next_cap_flag;
      ext_prev <= ext_clock_pin_i;
      trig_prev <= trig_src;
    end
  end

  // ==========================================================
  // outputs
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      cpu_rdata_o <= 8'h00;
      count_value_o <= timer16_pkg::COUNT_RESET;
      at_bottom_o <= 1'b1;
      at_top_o <= 1'b0;
      overflow_irq_o <= 1'b0;
      capture_irq_o <= 1'b0;
    end else begin
      cpu_rdata_o <= cpu_rd_i ? next_rdata : 8'h00;
      count_value_o <= next_count;
      at_bottom_o <= (next_count == timer16_pkg::BOTTOM_VALUE);
      at_top_o <= (next_count == top_value);
      overflow_irq_o <= next_ovf_flag && overflow_irq_enable_i;
      capture_irq_o <= next_cap_flag && capture_irq_enable_i;
    end
  end

  // ==========================================================
  // assertions
  a_cnt_write_wins: assert property (@(posedge mclk_i) disable iff (srst_i)
    wr_cnt_low |=> count_value == {$past(temp_high), $past(cpu_wdata_i)})
    else $error("counter write lost");
  a_temp_on_read: assert property (@(posedge mclk_i) disable iff (srst_i)
    rd_cnt_low && !wr_high |=> temp_high == $past(count_value[15:8]))
    else $error("temp not loaded on counter low read");
  a_stop_holds: assert property (@(posedge mclk_i) disable iff (srst_i)
    clock_select_field_i == timer16_pkg::CS_STOP && !wr_cnt_low |=> $stable(count_value))
    else $error("counter moved while stopped");
  a_step_one_up: assert property (@(posedge mclk_i) disable iff (srst_i)
    timer_tick && !wr_cnt_low && wgm == 4'h0 |=> count_value == $past(count_value) + 16'h0001)
    else $error("counter did not step by one");
  a_capture_copy: assert property (@(posedge mclk_i) disable iff (srst_i)
    capture_evt |=> capture_flag && capture_register == $past(count_value))
    else $error("capture copy or flag missing");
  a_capture_locked: assert property (@(posedge mclk_i) disable iff (srst_i)
    wr_cap_low && !icr_top_mode && !capture_evt |=> $stable(capture_register))
    else $error("capture register accepted a write");
  a_cap_irq_tie: assert property (@(posedge mclk_i) disable iff (srst_i)
    capture_irq_o |-> capture_flag && $past(capture_irq_enable_i))
    else $error("capture request without flag");
  a_ovf_normal: assert property (@(posedge mclk_i) disable iff (srst_i)
    timer_tick && wgm == 4'h0 && !wr_cnt_low && count_value == timer16_pkg::MAX_VALUE
    |=> overflow_flag && count_value == timer16_pkg::BOTTOM_VALUE)
    else $error("overflow not flagged at wrap");
  a_flag_clear_one: assert property (@(posedge mclk_i) disable iff (srst_i)
    wr_flags && cpu_wdata_i[timer16_pkg::FLAG_CAP_BIT] && !capture_evt |=> !capture_flag)
    else $error("capture flag not cleared");
  c_capture: cover property (@(posedge mclk_i) disable iff (srst_i) capture_evt);
  c_overflow: cover property (@(posedge mclk_i) disable iff (srst_i) ovf_event);
  c_write_vs_tick: cover property (@(posedge mclk_i) disable iff (srst_i)
    wr_cnt_low && timer_tick);
endmodule

// ===== verilog/timer16_pkg.sv
// constants shared by the 16-bit timer counter and capture core
package timer16_pkg;
  // ==========================================================
  // cpu i/o locations
  localparam logic [2:0] LOC_CNT_LOW = 3'h0;
  localparam logic [2:0] LOC_CNT_HIGH = 3'h1;
  localparam logic [2:0] LOC_CAP_LOW = 3'h2;
  localparam logic [2:0] LOC_CAP_HIGH = 3'h3;
  localparam logic [2:0] LOC_CMPA_LOW = 3'h4;
  localparam logic [2:0] LOC_CMPA_HIGH = 3'h5;
  localparam logic [2:0] LOC_FLAGS = 3'h6;
  // ==========================================================
  // flag location bit positions
  localparam int FLAG_OVF_BIT = 0;
  localparam int FLAG_CAP_BIT = 5;
  // ==========================================================
  // reset values and fixed tops
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] CAPTURE_RESET = 16'h0000;
  localparam logic [15:0] COMPARE_RESET = 16'h0000;
  localparam logic [7:0] TEMP_RESET = 8'h00;
  localparam logic [15:0] BOTTOM_VALUE = 16'h0000;
  localparam logic [15:0] MAX_VALUE = 16'hffff;
  localparam logic [15:0] TOP_8BIT = 16'h00ff;
  localparam logic [15:0] TOP_9BIT = 16'h01ff;
  localparam logic [15:0] TOP_10BIT = 16'h03ff;
  // ==========================================================
  // clock select codes
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_SYSCLK = 3'h1;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;
endpackage

// ===== testbench/cpu_bus_model.sv
// cpu side of the timer byte bus
`timescale 1ns/1ps
module cpu_bus_model (
  // clock
  input wire logic clk_i,
  // byte bus
  output logic [2:0] addr_o,
  output logic rd_o,
  output logic wr_o,
  output logic [7:0] wdata_o,
  input wire logic [7:0] rdata_i
);
  initial begin
    addr_o = 3'h7;
    rd_o = 1'b0;
    wr_o = 1'b0;
    wdata_o = 8'h00;
  end
  // ==========================================
  // byte cycles
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_i);
    #1;
    addr_o = a;
    wdata_o = d;
    wr_o = 1'b1;
    @(posedge clk_i);
    #1;
    wr_o = 1'b0;
    // released data is garbage, not the last byte
    wdata_o = ~d;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk_i);
    #1;
    addr_o = a;
    rd_o = 1'b1;
    @(posedge clk_i);
    #1;
    rd_o = 1'b0;
    d = rdata_i;
  endtask
  // ==========================================
  // word cycles, never split by other accesses
  task automatic wr16(input logic [2:0] lo, input logic [15:0] v);
    wr(lo + 3'h1, v[15:8]);
    wr(lo, v[7:0]);
  endtask
  task automatic rd16(input logic [2:0] lo, output logic [15:0] v);
    rd(lo, v[7:0]);
    rd(lo + 3'h1, v[15:8]);
  endtask
endmodule

// ===== testbench/tb_timer16_counter_capture.sv
// self-checking bench for the timer counter and capture core
`timescale 1ns/1ps
module tb_timer16_counter_capture;
  logic mclk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [2:0] addr, cs = 3'h0;
  logic rd, wr, bot, top, ovf_irq, cap_irq;
  logic [7:0] wdata, rdata, b;
  logic [3:0] mode = 4'h0, tick = 4'h0;
  logic rise = 1'b1, use_cmp = 1'b0, cap_ie = 1'b1, cap_ack = 1'b0, ovf_ack = 1'b0;
  logic ext = 1'b0, pin = 1'b0, cmp = 1'b0, ovf_ie = 1'b1;
  logic [15:0] cnt_o, w, v;
  int error_cnt = 0, n_compared = 0, seed = 20336;
  int exp_cnt, cmpa_val, cap_val, going_down = 0;
  int md_tab[16] = '{0, 5, 6, 7, 12, 4, 1, 3, 9, 14, 15, 8, 13, 2, 10, 11};
  int st_tab[16] = '{'hfffe, 'h00fe, 'h01fe, 'h03fe, 'h1276, 'h120e, 'h00fd, 'h0001, 'h120f,
    'h1276, 'h120e, 'h1277, 'hfffe, 'h01fe, 'h0002, 'h1210};
  always #50 mclk_i = ~mclk_i;
  timer16_counter_capture u_timer16_counter_capture (.mclk_i(mclk_i), .srst_i(srst_i),
    .cpu_addr_i(addr), .cpu_rd_i(rd), .cpu_wr_i(wr), .cpu_wdata_i(wdata), .cpu_rdata_o(rdata),
    .clock_select_field_i(cs), .waveform_mode_field_i(mode), .capture_rising_i(rise),
    .use_comparator_i(use_cmp), .capture_irq_enable_i(cap_ie), .overflow_irq_enable_i(ovf_ie),
    .capture_irq_ack_i(cap_ack), .overflow_irq_ack_i(ovf_ack), .prescale_tick_i(tick),
    .ext_clock_pin_i(ext), .capture_input_pin_i(pin), .comparator_output_i(cmp),
    .count_value_o(cnt_o), .at_bottom_o(bot), .at_top_o(top), .overflow_irq_o(ovf_irq),
    .capture_irq_o(cap_irq));
  cpu_bus_model u_cpu_bus_model (.clk_i(mclk_i), .addr_o(addr), .rd_o(rd), .wr_o(wr),
    .wdata_o(wdata), .rdata_i(rdata));
  // ==========================================
  // helpers and reference model
  function automatic logic [15:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[15:0];
  endfunction
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  function automatic int top_of(input int md);
    case (md)
      1, 5: return 'h00ff;
      2, 6: return 'h01ff;
      3, 7: return 'h03ff;
      4, 9, 11, 15: return cmpa_val;
      8, 10, 12, 14: return cap_val;
      default: return 'hffff;
    endcase
  endfunction
  task automatic set_count(input logic [15:0] x);
    u_cpu_bus_model.wr16(timer16_pkg::LOC_CNT_LOW, x);
    exp_cnt = x;
  endtask
  // one tick per system clock, model stepped alongside
  task automatic run(input int n);
    int t;
    cs = 3'h1;
    repeat (n) begin
      cyc(1);
      t = top_of(mode);
      if (mode inside {1, 2, 3, 8, 9, 10, 11}) begin
        going_down = (exp_cnt == t) ? 1 : (exp_cnt == 0) ? 0 : going_down;
        exp_cnt = going_down ? exp_cnt - 1 : exp_cnt + 1;
      end else begin
        // single-slope modes always count up
        going_down = 0;
        exp_cnt = (exp_cnt == t) ? 0 : exp_cnt + 1;
      end
      chk("count", exp_cnt[15:0], cnt_o);
      chk("top", {15'h0, exp_cnt == t}, {15'h0, top});
      chk("bottom", {15'h0, exp_cnt == 0}, {15'h0, bot});
    end
    cs = 3'h0;
  endtask
  task automatic trig(input logic p, input logic c, input logic e);
    pin = p;
    cmp = c;
    cyc(3);
    chk("cap_irq", {15'h0, e}, {15'h0, cap_irq});
  endtask
  // ==========================================
  // scenarios
  initial begin
    cyc(2);
    srst_i = 1'b0;
    chk("bottom", 16'h0001, {15'h0, bot});
    repeat (4) begin
      w = xs();
      set_count(w);
      cyc(3);
      u_cpu_bus_model.rd16(timer16_pkg::LOC_CNT_LOW, v);
      chk("count", w, cnt_o);
      chk("read", w, v);
    end
    set_count(16'h12ff);
    u_cpu_bus_model.rd(timer16_pkg::LOC_CNT_LOW, b);
    run(2);
    u_cpu_bus_model.rd(timer16_pkg::LOC_CNT_HIGH, b);
    chk("temp", 16'h0012, {8'h00, b});
    cs = 3'h1;
    u_cpu_bus_model.wr16(timer16_pkg::LOC_CNT_LOW, 16'ha5a5);
    cs = 3'h0;
    chk("count", 16'ha5a5, cnt_o);
    mode = 4'hc;
    u_cpu_bus_model.wr(timer16_pkg::LOC_CNT_HIGH, 8'h12);
    u_cpu_bus_model.wr(timer16_pkg::LOC_CAP_LOW, 8'h78);
    u_cpu_bus_model.wr(timer16_pkg::LOC_CMPA_LOW, 8'h10);
    cap_val = 'h1278;
    cmpa_val = 'h1210;
    mode = 4'h0;
    u_cpu_bus_model.wr16(timer16_pkg::LOC_CAP_LOW, 16'h0303);
    u_cpu_bus_model.wr(timer16_pkg::LOC_CNT_HIGH, 8'h5a);
    u_cpu_bus_model.rd16(timer16_pkg::LOC_CMPA_LOW, v);
    chk("compare", 16'h1210, v);
    u_cpu_bus_model.rd(timer16_pkg::LOC_CNT_HIGH, b);
    chk("temp", 16'h005a, {8'h00, b});
    u_cpu_bus_model.rd16(timer16_pkg::LOC_CAP_LOW, v);
    chk("capture", 16'h1278, v);
    // every waveform mode once; dual-slope entries chain their direction
    foreach (md_tab[i]) begin
      mode = 4'(md_tab[i]);
      set_count(16'(st_tab[i]));
      run(3);
    end
    chk("ovf_irq", 16'h0001, {15'h0, ovf_irq});
    ovf_ie = 1'b0;
    cyc(1);
    chk("ovf_irq", 16'h0000, {15'h0, ovf_irq});
    ovf_ie = 1'b1;
    ovf_ack = 1'b1;
    cyc(1);
    ovf_ack = 1'b0;
    cyc(2);
    chk("ovf_irq", 16'h0000, {15'h0, ovf_irq});
    mode = 4'h0;
    // selects 2..5 take one prescale bit, 6 and 7 the pin
    for (int k = 2; k < 8; k++) begin
      set_count(16'h0200);
      cs = 3'(k);
      repeat (3) begin
        tick = ~4'(1 << (k - 2));
        ext = 1'b1;
        cyc(1);
        tick = 4'(1 << (k - 2));
        cyc(1);
        tick = 4'h0;
        ext = 1'b0;
        cyc(2);
      end
      cyc(3);
      cs = 3'h0;
      chk("count", 16'h0203, cnt_o);
    end
    set_count(16'h0abc);
    trig(1'b1, 1'b0, 1'b1);
    u_cpu_bus_model.rd16(timer16_pkg::LOC_CAP_LOW, v);
    chk("capture", 16'h0abc, v);
    u_cpu_bus_model.rd(timer16_pkg::LOC_FLAGS, b);
    chk("flags", 16'h0020, {8'h00, b});
    u_cpu_bus_model.wr(timer16_pkg::LOC_FLAGS, 8'h20);
    trig(1'b0, 1'b0, 1'b0);
    rise = 1'b0;
    set_count(16'h0bcd);
    trig(1'b1, 1'b0, 1'b0);
    trig(1'b0, 1'b0, 1'b1);
    u_cpu_bus_model.rd16(timer16_pkg::LOC_CAP_LOW, v);
    chk("capture", 16'h0bcd, v);
    cap_ack = 1'b1;
    cyc(1);
    cap_ack = 1'b0;
    chk("cap_irq", 16'h0000, {15'h0, cap_irq});
    rise = 1'b1;
    use_cmp = 1'b1;
    cap_ie = 1'b0;
    set_count(16'h0cde);
    // only the comparator moves, so a pin-fed capture would miss
    trig(1'b0, 1'b1, 1'b0);
    cap_ie = 1'b1;
    trig(1'b0, 1'b1, 1'b1);
    u_cpu_bus_model.rd16(timer16_pkg::LOC_CAP_LOW, v);
    chk("capture", 16'h0cde, v);
    close_out();
  end
  // hang guard, far beyond the few hundred cycles the run needs
  initial begin
    #(5000 * 100);
    error_cnt++;
    close_out();
  end
endmodule
